//--- design/flash_host.sv
// Host controller that runs program and erase sequences on the flash pins.
`default_nettype none

// Notes on behaviour
// - No more than 528 serial strobes are sent for one sector.
// - No command, not even FFH, is written while busy is low.
// - An additively programmed sector takes at most 15 programs per erase.
// - A single-shot sector must be erased before it is programmed again.
// - Usable sectors carry 1C,71,C7,1C,71,C7 at 200H-205H and EE to 20FH; this host does not check these marks.
// - Sectors marked invalid are never programmed or erased.
// - A failed sector is excluded and the data goes elsewhere; this host only reports the failure with ok low.
// - Every sector read passes through multi-bit error correction; this host performs no sector reads.
// - The guard input stays released while ready is low or busy is low.
// - Commands and data go with select low, addresses with select high.
// - Reserved status bits are masked when polling.
module flash_host (
   input  wire logic                       clock,
   input  wire logic                       rst,
   input  wire logic                       enable,
   input  wire flash_host_pkg::request_t   req,
   input  wire logic                       req_valid,
   output logic                            req_ready,
   input  wire logic                       sector_bad,
   input  wire logic [7:0]                 wdata,
   input  wire logic                       wdata_valid,
   output logic                            wdata_ready,
   input  wire logic                       wdata_last,
   output flash_host_pkg::result_t         result,
   output logic                            result_valid,
   input  wire logic                       busy_n_pin,
   input  wire logic [7:0]                 io_in,
   output logic [7:0]                      io_out,
   output logic                            io_oe,
   output logic                            write_n,
   output logic                            output_en_n,
   output logic                            cmd_data_select_n,
   output logic                            serial_data_strobe,
   output logic                            array_guard_n
);
   typedef enum logic [6:0] {
      S_IDLE  = 7'h01,
      S_CMD   = 7'h02,
      S_GAP   = 7'h04,
      S_DATA  = 7'h08,
      S_WAIT  = 7'h10,
      S_POLL  = 7'h20,
      S_DONE  = 7'h40
   } state_t;

   state_t                   state;
   flash_host_pkg::request_t cur;
   logic [2:0]  step;
   logic [31:0] timer;
   logic [9:0]  sent;
   logic [1:0]  busy_sync;
   logic [7:0]  io_s1;
   logic [7:0]  io_s2;
   logic        busy_low;
   logic [7:0]  f_data;
   logic        f_valid;
   logic        f_ready;
   logic [7:0]  masked;
   logic        phase;
   logic [3:0]  add_count [4];
   logic [3:0]  single_used;
   logic        last_in;
   logic        loaded;
   logic        data_done;
   logic        status_ok;

   // The first stage of each synchroniser feeds only its second stage.
   always_ff @(posedge clock) begin
      if (rst) begin
         busy_sync <= 2'h3;
         io_s1     <= 8'h00;
         io_s2     <= 8'h00;
      end else if (enable) begin
         busy_sync <= {busy_sync[0], busy_n_pin};
         io_s1     <= io_in;
         io_s2     <= io_s1;
      end
   end
   assign busy_low = !busy_sync[1];

   flash_host_fifo #(.WIDTH(flash_host_pkg::DATA_W),
                     .DEPTH(flash_host_pkg::FIFO_DEPTH)) fifo (
      .clock     (clock),
      .rst       (rst),
      .enable    (enable),
      .in_data   (wdata),
      .in_valid  (wdata_valid),
      .in_ready  (wdata_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_ready)
   );

   assign masked = io_s2 & flash_host_pkg::READY_MASK;
   assign f_ready = state == S_DATA && phase &&
                    sent < 10'(flash_host_pkg::SECTOR_BYTES);
   assign req_ready = state == S_IDLE && !busy_low;
   assign array_guard_n = 1'b1;
   assign data_done = state == S_DATA && !phase &&
                      (sent == 10'(flash_host_pkg::SECTOR_BYTES) ||
                       (last_in && !f_valid));
   assign status_ok = masked[flash_host_pkg::READY_BIT] &&
                      !masked[flash_host_pkg::ERASE_FAIL_BIT] &&
                      !masked[flash_host_pkg::PROG_FAIL_BIT] &&
                      !masked[flash_host_pkg::VERIFY_FAIL_BIT];

   // The last flag is only a level beside the incoming byte, so it is caught
   // as that byte enters the FIFO; a new last byte wins over the clear.
   always_ff @(posedge clock) begin
      if (rst) begin
         last_in <= 1'b0;
      end else if (enable) begin
         if (wdata_valid && wdata_ready && wdata_last) begin
            last_in <= 1'b1;
         end else if (data_done) begin
            last_in <= 1'b0;
         end
      end
   end

   function automatic logic [7:0] cmd_byte(input flash_host_pkg::request_t r,
                                           input logic [2:0] s);
      case (s)
         3'h0:    cmd_byte = r.cmd1;
         3'h1:    cmd_byte = r.sector[7:0];
         3'h2:    cmd_byte = r.sector[15:8];
         default: cmd_byte = r.cmd2;
      endcase
   endfunction

   // Additive program counts kept per low sector bits; a real system keeps
   // a full table in memory, this small one shares each entry among sectors with equal low bits.
   always_ff @(posedge clock) begin
      if (rst) begin
         state        <= S_IDLE;
         cur          <= '0;
         step         <= 3'h0;
         timer        <= 32'h0;
         sent         <= 10'h0;
         phase        <= 1'b0;
         io_out       <= 8'h00;
         io_oe        <= 1'b0;
         write_n      <= 1'b1;
         output_en_n  <= 1'b1;
         cmd_data_select_n  <= 1'b0;
         serial_data_strobe <= 1'b0;
         result       <= '0;
         result_valid <= 1'b0;
         loaded       <= 1'b0;
         single_used  <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            add_count[i] <= 4'h0;
         end
      end else if (enable) begin
         result_valid <= 1'b0;
         serial_data_strobe <= 1'b0;
         case (state)
            S_IDLE: begin
               if (req_valid && req_ready) begin
                  cur <= req;
                  if (sector_bad || (req.op == flash_host_pkg::OP_ADDITIVE &&
                      add_count[req.sector[1:0]] ==
                      4'(flash_host_pkg::ADDITIVE_LIMIT)) ||
                      (req.op != flash_host_pkg::OP_ERASE &&
                       single_used[req.sector[1:0]])) begin
                     result       <= '{ok: 1'b0, timeout: 1'b0,
                                       refused: 1'b1, status: 8'h00};
                     result_valid <= 1'b1;
                  end else begin
                     state <= S_CMD;
                     step  <= 3'h0;
                     timer <= 32'h0;
                  end
               end
            end
            S_CMD: begin
               cmd_data_select_n <= step == 3'h1 || step == 3'h2;
               io_out  <= cmd_byte(cur, step);
               io_oe   <= 1'b1;
               timer   <= timer + 32'h1;
               write_n <= timer >= 32'(flash_host_pkg::STROBE_CYCLES);
               if (timer == 32'(2 * flash_host_pkg::STROBE_CYCLES)) begin
                  timer <= 32'h0;
                  step  <= step + 3'h1;
                  if (step == 3'h2 && cur.op != flash_host_pkg::OP_ERASE) begin
                     state <= S_GAP;
                  end else if (step == 3'h3) begin
                     state <= S_WAIT;
                     io_oe <= 1'b0;
                  end
               end
            end
            S_GAP: begin
               cmd_data_select_n <= 1'b0;
               timer <= timer + 32'h1;
               if (timer == 32'(flash_host_pkg::WSD_CYCLES)) begin
                  state <= S_DATA;
                  sent  <= 10'h0;
                  phase <= 1'b0;
               end
            end
            S_DATA: begin
               phase <= !phase;
               // byte before strobe
               // The strobe trails its byte by a cycle, so the byte already
               // stands on the bus when the device latches it.
               loaded <= f_valid && f_ready;
               serial_data_strobe <= loaded;
               if (f_valid && f_ready) begin
                  io_out <= f_data;
                  sent   <= sent + 10'h1;
               end
               if (data_done) begin
                  state <= S_CMD;
                  step  <= 3'h3;
                  timer <= 32'h0;
               end
            end
            S_WAIT: begin
               timer <= timer + 32'h1;
               if (timer == 32'(flash_host_pkg::TIMEOUT_CYCLES)) begin
                  result       <= '{ok: 1'b0, timeout: 1'b1,
                                   refused: 1'b0, status: 8'h00};
                  result_valid <= 1'b1;
                  state        <= S_IDLE;
               end else if (timer > 32'h8 && !busy_low) begin
                  state       <= S_POLL;
                  output_en_n <= 1'b0;
                  timer       <= 32'h0;
               end
            end
            S_POLL: begin
               timer <= timer + 32'h1;
               if (timer == 32'h4) begin
                  output_en_n <= 1'b1;
                  state       <= S_DONE;
               end
            end
            S_DONE: begin
               result <= '{ok: status_ok, timeout: 1'b0, refused: 1'b0,
                         status: masked};
               result_valid <= 1'b1;
               if (cur.op == flash_host_pkg::OP_ERASE) begin
                  add_count[cur.sector[1:0]] <= 4'h0;
               end else if (cur.op == flash_host_pkg::OP_ADDITIVE) begin
                  add_count[cur.sector[1:0]] <=
                     add_count[cur.sector[1:0]] + 4'h1;
               end
               if (cur.op == flash_host_pkg::OP_ERASE) begin
                  single_used[cur.sector[1:0]] <= 1'b0;
               end else if (cur.op == flash_host_pkg::OP_SINGLE &&
                            status_ok) begin
                  single_used[cur.sector[1:0]] <= 1'b1;
               end
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   strobe_limit_a: assert property (@(posedge clock) disable iff (rst)
      serial_data_strobe |-> sent <= 10'(flash_host_pkg::SECTOR_BYTES))
      else $error("too many serial strobes");
   no_cmd_busy_a: assert property (@(posedge clock) disable iff (rst)
      busy_low |-> (write_n && !req_ready))
      else $error("command accepted while busy");
   guard_high_a: assert property (@(posedge clock) disable iff (rst)
      busy_low |-> array_guard_n)
      else $error("guard asserted during busy");
   wait_bound_a: assert property (@(posedge clock) disable iff (rst)
      state == S_WAIT |-> timer <= 32'(flash_host_pkg::TIMEOUT_CYCLES))
      else $error("wait exceeded timeout");
   strobe_data_a: assert property (@(posedge clock) disable iff (rst)
      $rose(serial_data_strobe) |-> $stable(io_out))
      else $error("data changed with strobe");
   strobe_phase_a: assert property (@(posedge clock) disable iff (rst)
      serial_data_strobe |-> (!cmd_data_select_n && io_oe && write_n))
      else $error("strobe outside data phase");
endmodule
`default_nettype wire

//--- design/flash_host_pkg.sv
// Package of constants and types for the sector flash host controller.
`default_nettype none
package flash_host_pkg;
   localparam int CLOCK_MHZ = 100;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int SECTOR_BYTES = 528;
   localparam int ADDITIVE_LIMIT = 15;
   localparam int ERASE_MAX_MS = 20;
   localparam int MARGIN_MS = 2;
   localparam int TIMEOUT_CYCLES = (ERASE_MAX_MS + MARGIN_MS) * 1000 * CLOCK_MHZ;
   localparam int STROBE_NS = 60;
   localparam int STROBE_CYCLES = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
   localparam int WSD_US = 5;
   localparam int WSD_CYCLES = WSD_US * CLOCK_MHZ;
   localparam logic [7:0] ABORT_CMD = 8'hff;
   localparam logic [7:0] READY_MASK = 8'hb8;
   localparam int READY_BIT = 7;
   localparam int ERASE_FAIL_BIT = 5;
   localparam int PROG_FAIL_BIT = 4;
   localparam int VERIFY_FAIL_BIT = 3;
   localparam logic [7:0] MARK_A = 8'h1c;
   localparam logic [7:0] MARK_B = 8'h71;
   localparam logic [7:0] MARK_C = 8'hc7;
   localparam logic [7:0] MARK_FILL = 8'hee;
   localparam logic [9:0] MARK_FIRST = 10'h200;
   localparam logic [9:0] MARK_LAST = 10'h20f;

   typedef enum logic [1:0] {
      OP_ERASE    = 2'h0,
      OP_ADDITIVE = 2'h1,
      OP_SINGLE   = 2'h2
   } op_t;

   typedef struct packed {
      op_t         op;
      logic [15:0] sector;
      logic [7:0]  cmd1;
      logic [7:0]  cmd2;
   } request_t;

   typedef struct packed {
      logic       ok;
      logic       timeout;
      logic       refused;
      logic [7:0] status;
   } result_t;
endpackage
`default_nettype wire

//--- design/flash_host_fifo.sv
// Parameterised valid/ready FIFO for program data.
`default_nettype none
module flash_host_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             enable,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr;
   logic [AW-1:0]    rd;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data  = mem[rd];
   assign push      = enable && in_valid && in_ready;
   assign pop       = enable && out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr    <= '0;
         rd    <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr <= wr + AW'(1);
         end
         if (pop) begin
            rd <= rd + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

//--- dv/flash_dev_model.sv
// Behavioural model of the sector flash device seen from its pins.
`default_nettype none
module flash_dev_model (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [7:0]  io_out,
   input  wire logic        write_n,
   input  wire logic        output_en_n,
   input  wire logic        cmd_data_select_n,
   input  wire logic        serial_data_strobe,
   input  wire logic        array_guard_n,
   input  wire logic [7:0]  fail_bits,
   input  wire logic [15:0] busy_cycles,
   output logic             busy_n_pin,
   output logic [7:0]       io_in,
   output int               viol,
   output int               strobes,
   output logic [7:0]       csum,
   output logic [15:0]      sector
);
   timeunit 1ns;
   timeprecision 1ps;
   int         wcount;
   int         busy_left;
   bit         pending;
   logic [7:0] noise;
   initial begin
      viol = 0;
      wcount = 0;
      busy_left = 0;
      noise = 8'h00;
   end
   assign busy_n_pin = (pending || busy_left > 0) ? 1'b0 : 1'b1;
   assign io_in = output_en_n ? noise
                : (busy_n_pin ? (8'h80 | fail_bits) : 8'h00);
   always @(posedge write_n) begin
      if (busy_n_pin !== 1'b1 ||
          cmd_data_select_n !== (wcount == 1 || wcount == 2))
         viol++;
      if (wcount == 0) begin
         strobes = 0;
         csum = 8'h00;
      end
      if (wcount == 1)
         sector[7:0] = io_out;
      if (wcount == 2)
         sector[15:8] = io_out;
      if (wcount == 3)
         pending = 1'b1;
      wcount = (wcount + 1) % 4;
   end
   always @(posedge serial_data_strobe) begin
      if (cmd_data_select_n !== 1'b0 || strobes >= 528)
         viol++;
      strobes++;
      csum ^= io_out;
   end
   always @(posedge clock) begin
      // A released bus must not keep its last value, so it keeps moving.
      noise <= noise + 8'h35;
      if (busy_left > 0 && array_guard_n !== 1'b1)
         viol++;
      if (rst) begin
         // Outputs leave unknown on the first reset edge; that is no write.
         viol = 0;
         pending = 1'b0;
         busy_left = 0;
         wcount = 0;
      end else if (pending) begin
         busy_left = int'(busy_cycles);
         pending = 1'b0;
      end else if (busy_left > 0)
         busy_left--;
   end
endmodule
`default_nettype wire

//--- dv/flash_host_test.sv
// Self-checking bench for the flash host controller against a device model.
`default_nettype none
module flash_host_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                     clock = 1'b0;
   logic                     rst = 1'b1;
   logic                     enable = 1'b1;
   flash_host_pkg::request_t req = '0;
   logic                     req_valid = 1'b0;
   logic                     req_ready;
   logic                     sector_bad = 1'b0;
   logic [7:0]               wdata = 8'h00;
   logic                     wdata_valid = 1'b0;
   logic                     wdata_ready;
   logic                     wdata_last = 1'b0;
   flash_host_pkg::result_t  result;
   logic                     result_valid;
   logic                     busy_n_pin;
   logic [7:0]               io_in;
   logic [7:0]               io_out;
   logic                     io_oe;
   logic                     write_n;
   logic                     output_en_n;
   logic                     cmd_data_select_n;
   logic                     serial_data_strobe;
   logic                     array_guard_n;
   logic [7:0]               fail_bits = 8'h00;
   logic [15:0]              busy_cycles = 16'h0028;
   int                       viol;
   int                       strobes;
   logic [7:0]               csum;
   logic [15:0]              sector;
   logic [11:0]              expq[$];
   logic [11:0]              e;
   logic [2:0]               flags;
   logic [7:0]               st;
   logic [5:0]               pins;
   logic [7:0]               fails[4] = '{8'h20, 8'h10, 8'h08, 8'h47};
   int                       err_count = 0;
   int                       tests_run = 0;
   int                       results_seen = 0;
   int                       full_seen = 0;

   flash_host DUT (.clock, .rst, .enable, .req, .req_valid, .req_ready,
      .sector_bad, .wdata, .wdata_valid, .wdata_ready, .wdata_last, .result,
      .result_valid, .busy_n_pin, .io_in, .io_out, .io_oe, .write_n,
      .output_en_n, .cmd_data_select_n, .serial_data_strobe, .array_guard_n);
   flash_dev_model device (.clock, .rst, .io_out, .write_n, .output_en_n,
      .cmd_data_select_n, .serial_data_strobe, .array_guard_n, .fail_bits,
      .busy_cycles, .busy_n_pin, .io_in, .viol, .strobes, .csum, .sector);

   assign flags = {result.ok, result.timeout, result.refused};
   assign st = result.status & flash_host_pkg::READY_MASK;
   assign pins = {write_n, output_en_n, io_oe, serial_data_strobe,
                  cmd_data_select_n, array_guard_n};

   initial forever #5 clock = ~clock;

   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (exp !== got) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // A result with no expectation pending gets flags that never occur.
   always @(posedge clock) begin
      if (wdata_valid && wdata_ready === 1'b0)
         full_seen++;
      if (result_valid === 1'b1) begin
         results_seen++;
         e = (expq.size() > 0) ? expq.pop_front() : 12'hfff;
         check("flags", 16'(e[10:8]), 16'(flags));
         if (e[11])
            check("status", 16'(e[7:0]), 16'(st));
      end
   end

   task automatic send_data(int n, output logic [7:0] sum);
      sum = 8'h00;
      for (int i = 0; i < n; i++) begin
         wdata <= 8'($urandom);
         wdata_last <= (i == n - 1);
         wdata_valid <= 1'b1;
         @(posedge clock);
         while (wdata_ready !== 1'b1)
            @(posedge clock);
         sum ^= wdata;
      end
      wdata_valid <= 1'b0;
      wdata_last <= 1'b0;
   endtask

   task automatic run_op(flash_host_pkg::op_t op, logic [15:0] sec, int n,
                         logic mark, logic refuse, logic [7:0] fb);
      int         seen;
      logic [7:0] sum;
      logic       ok;
      seen = results_seen;
      ok = !refuse && (fb & flash_host_pkg::READY_MASK & 8'h7f) == 8'h00;
      fail_bits <= fb;
      sector_bad <= mark;
      expq.push_back({!refuse, ok, 1'b0, refuse,
                      (8'h80 | fb) & flash_host_pkg::READY_MASK});
      req <= '{op, sec, 8'($urandom % 255), 8'($urandom % 255)};
      req_valid <= 1'b1;
      fork
         send_data(n, sum);
         begin
            @(posedge clock);
            while (req_ready !== 1'b1)
               @(posedge clock);
            req_valid <= 1'b0;
         end
      join
      while (results_seen == seen)
         @(posedge clock);
      @(posedge clock);
      if (!refuse) begin
         check("strobes", 16'(n), 16'(strobes));
         check("data", 16'(sum), 16'(csum));
         check("sector", sec, sector);
      end
   endtask

   initial begin
      void'($urandom(54));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check("idle pins", 16'h0031, 16'(pins));
      run_op(flash_host_pkg::OP_ERASE, 16'h0100, 0, 0, 0, 8'h00);
      run_op(flash_host_pkg::OP_SINGLE, 16'h0101, 20, 0, 0, 8'h00);
      check("fifo full", 16'h0001, 16'(full_seen > 0));
      run_op(flash_host_pkg::OP_SINGLE, 16'h0101, 0, 0, 1, 8'h00);
      run_op(flash_host_pkg::OP_ERASE, 16'h0101, 0, 0, 0, 8'h00);
      run_op(flash_host_pkg::OP_SINGLE, 16'h0101, 2, 0, 0, 8'h00);
      foreach (fails[i])
         run_op(flash_host_pkg::OP_SINGLE, {14'($urandom), 2'h3}, 3,
                0, 0, fails[i]);
      run_op(flash_host_pkg::OP_ERASE, 16'h0203, 0, 1, 1, 8'h00);
      run_op(flash_host_pkg::OP_ADDITIVE, 16'h0203, 0, 1, 1, 8'h00);
      run_op(flash_host_pkg::OP_ERASE, 16'h0302, 0, 0, 0, 8'h00);
      for (int i = 0; i <= 15; i++)
         run_op(flash_host_pkg::OP_ADDITIVE, 16'h0302, (i < 15) ? 1 : 0,
                0, i == 15, 8'h00);
      busy_cycles <= 16'h0fa0;
      run_op(flash_host_pkg::OP_ERASE, 16'h0302, 0, 0, 0, 8'h00);
      run_op(flash_host_pkg::OP_ADDITIVE, 16'h0302, 2, 0, 0, 8'h00);
      check("violations", 16'h0000, 16'(viol));
      print_verdict();
   end

   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
